/* File: common/adcctl_defs.svh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADCCTL_OFF_SC1      12'h000
`define ADCCTL_OFF_SC2      12'h004
`define ADCCTL_OFF_CFG      12'h008
`define ADCCTL_OFF_RESULT   12'h00C
`define ADCCTL_OFF_CMPVAL   12'h010
`define ADCCTL_OFF_PINEN    12'h014
`define ADCCTL_OFF_PORTIN   12'h018

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCCTL_SC1_CH_LSB   0
`define ADCCTL_SC1_CH_MSB   4
`define ADCCTL_SC1_CONT     5
`define ADCCTL_SC1_IE       6
`define ADCCTL_SC1_COCO     7
`define ADCCTL_SC2_ACFGT    4
`define ADCCTL_SC2_ACFE     5
`define ADCCTL_SC2_TRG      6
`define ADCCTL_SC2_ACT      7
`define ADCCTL_CFG_CLK_LSB  0
`define ADCCTL_CFG_CLK_MSB  1
`define ADCCTL_CFG_MODE     2
`define ADCCTL_CFG_LSMP     4
`define ADCCTL_CFG_DIV_LSB  5
`define ADCCTL_CFG_DIV_MSB  6
`define ADCCTL_CFG_LPWR     7

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define ADCCTL_CH_NONE      5'h1F
`define ADCCTL_SC1_RESET    8'h1F
`define ADCCTL_CMP_RESET    10'h000
`define ADCCTL_SAMPLE_SHORT 4'h3
`define ADCCTL_SAMPLE_LONG  4'hF
`define ADCCTL_RES_BITS     10

`endif

/* File: common/adcctl_pkg.sv */
// Types shared by the converter control modules
package adcctl_pkg;
    typedef enum logic [3:0] {
        ADCCTL_IDLE   = 4'b0001,
        ADCCTL_SAMPLE = 4'b0010,
        ADCCTL_CONV   = 4'b0100,
        ADCCTL_DONE   = 4'b1000
    } adcctl_state_e;
    typedef logic [9:0] adcctl_data_t;
endpackage

/* File: rtl/adcctl_clk_div.sv */
// Converter clock source select and power-of-two divider producing an enable pulse
`timescale 1ns/1ps
`include "adcctl_defs.svh"
module adcctl_clk_div (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Source enables and selection
    input  wire logic [3:0] srcEn,
    input  wire logic [1:0] srcSel,
    input  wire logic [1:0] inputClockDivideSel,
    // Divided converter enable
    output logic            convTick
);
    import adcctl_pkg::*;

    logic [2:0] divCnt_ff;
    logic [2:0] divMask;
    logic       srcTick;

    // Four sources, each a one-cycle enable in the mclk domain
    assign srcTick = srcEn[srcSel];

    always_comb begin
        case (inputClockDivideSel)
            2'h0:    divMask = 3'h0;
            2'h1:    divMask = 3'h1;
            2'h2:    divMask = 3'h3;
            default: divMask = 3'h7;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            divCnt_ff <= 3'h0;
        end else if (srcTick) begin
            divCnt_ff <= divCnt_ff + 3'h1;
        end
    end

    // Divide by 1, 2, 4 or 8
    assign convTick = srcTick && ((divCnt_ff & divMask) == divMask);
endmodule

/* File: rtl/adcctl_sar.sv */
// Successive-approximation sequencer, one bit decided per converter tick
`timescale 1ns/1ps
`include "adcctl_defs.svh"
module adcctl_sar (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // Control
    input  wire logic                 tick,
    input  wire logic                 start,
    input  wire logic                 abort,
    input  wire logic [3:0]           sampleCycles,
    // Analog comparator
    input  wire logic                 cmpAbove,
    output adcctl_pkg::adcctl_data_t  trialCode,
    // Result
    output logic                      busy,
    output logic                      done,
    output adcctl_pkg::adcctl_data_t  result
);
    import adcctl_pkg::*;

    adcctl_state_e state_ff;
    adcctl_data_t  sar_ff;
    adcctl_data_t  res_ff;
    logic [3:0]    cnt_ff;
    logic [3:0]    bitIdx_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n || abort) begin
            // A control write that aborts may relaunch in the same cycle
            state_ff  <= (reset_n && start) ? ADCCTL_SAMPLE : ADCCTL_IDLE;
            sar_ff    <= 10'h000;
            cnt_ff    <= sampleCycles;
            bitIdx_ff <= 4'h0;
        end else begin
            case (state_ff)
                ADCCTL_IDLE: begin
                    if (start) begin
                        state_ff <= ADCCTL_SAMPLE;
                        cnt_ff   <= sampleCycles;
                    end
                end
                ADCCTL_SAMPLE: begin
                    if (tick) begin
                        if (cnt_ff == 4'h0) begin
                            state_ff  <= ADCCTL_CONV;
                            sar_ff    <= 10'h200;
                            bitIdx_ff <= 4'h9;
                        end else begin
                            cnt_ff <= cnt_ff - 4'h1;
                        end
                    end
                end
                ADCCTL_CONV: begin
                    // MSB-first binary search over 10 bits
                    if (tick) begin
                        sar_ff[bitIdx_ff] <= cmpAbove;
                        if (bitIdx_ff == 4'h0) begin
                            state_ff <= ADCCTL_DONE;
                        end else begin
                            sar_ff[bitIdx_ff - 4'h1] <= 1'b1;
                            bitIdx_ff <= bitIdx_ff - 4'h1;
                        end
                    end
                end
                ADCCTL_DONE: begin
                    state_ff <= ADCCTL_IDLE;
                end
                default: begin
                    state_ff <= ADCCTL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            res_ff <= 10'h000;
        end else if (state_ff == ADCCTL_CONV && tick && bitIdx_ff == 4'h0) begin
            res_ff <= {sar_ff[9:1], cmpAbove};
        end
    end

    assign trialCode = sar_ff;
    assign busy      = (state_ff != ADCCTL_IDLE);
    assign done      = (state_ff == ADCCTL_DONE) && !abort;
    assign result    = res_ff;
endmodule

/* File: rtl/adcctl_top.sv */
// Converter control: AHB-Lite registers, triggering, pin control, result and compare
`timescale 1ns/1ps
`include "adcctl_defs.svh"
module adcctl_top #(
    parameter int NUM_PINS = 28
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Converter clock sources and trigger
    input  wire logic [3:0]           clkSrcEn,
    input  wire logic                 hwConversionTriggerIn,
    // Analog front end
    input  wire logic                 cmpAbove,
    output adcctl_pkg::adcctl_data_t  trialCode,
    output logic [4:0]                channelSelect,
    output logic                      lowPower,
    output logic                      sampling,
    // Pin control
    input  wire logic [NUM_PINS-1:0]  padIn,
    output logic [NUM_PINS-1:0]       padOutEnMask,
    output logic [NUM_PINS-1:0]       padInBufEn,
    output logic [NUM_PINS-1:0]       padPullupMask,
    // Completion request
    output logic                      convIrq
);
    import adcctl_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [4:0]          channelSelect_ff;
    logic                contEn_ff;
    logic                irqEn_ff;
    logic                coco_ff;
    logic                hwTriggerSelect_ff;
    logic                cmpEn_ff;
    logic                cmpGe_ff;
    logic [1:0]          clkSel_ff;
    logic                mode8_ff;
    logic                longSample_ff;
    logic [1:0]          inputClockDivideSel_ff;
    logic                lowPower_ff;
    adcctl_data_t        cmpVal_ff;
    adcctl_data_t        result_ff;
    logic [NUM_PINS-1:0] analogPinEnable_ff;
    logic                seqActive_ff;
    logic                hwArmed_ff;

    // ****************************************************************
    // AHB-Lite data phase capture
    // ****************************************************************
    logic        dpWrite_ff;
    logic        dpRead_ff;
    logic [11:0] dpAddr_ff;
    logic        addrPhase;

    assign addrPhase = hsel && hready && htrans[1];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dpWrite_ff <= 1'b0;
            dpRead_ff  <= 1'b0;
            dpAddr_ff  <= 12'h000;
        end else if (hready) begin
            dpWrite_ff <= addrPhase && hwrite;
            dpRead_ff  <= addrPhase && !hwrite;
            dpAddr_ff  <= haddr;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wrSc1, wrSc2, wrCfg, wrCmp, wrPin, rdResult;
    assign wrSc1    = dpWrite_ff && (dpAddr_ff == `ADCCTL_OFF_SC1);
    assign wrSc2    = dpWrite_ff && (dpAddr_ff == `ADCCTL_OFF_SC2);
    assign wrCfg    = dpWrite_ff && (dpAddr_ff == `ADCCTL_OFF_CFG);
    assign wrCmp    = dpWrite_ff && (dpAddr_ff == `ADCCTL_OFF_CMPVAL);
    assign wrPin    = dpWrite_ff && (dpAddr_ff == `ADCCTL_OFF_PINEN);
    assign rdResult = dpRead_ff && (dpAddr_ff == `ADCCTL_OFF_RESULT);

    // ****************************************************************
    // Trigger synchroniser and edge detect
    // ****************************************************************
    logic trigMeta_ff, trigSync_ff, trigPrev_ff, trigRise;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trigMeta_ff <= 1'b0;
            trigSync_ff <= 1'b0;
            trigPrev_ff <= 1'b0;
        end else begin
            trigMeta_ff <= hwConversionTriggerIn;
            trigSync_ff <= trigMeta_ff;
            trigPrev_ff <= trigSync_ff;
        end
    end

    assign trigRise = trigSync_ff && !trigPrev_ff;

    // ****************************************************************
    // Clock divider and sequencer
    // ****************************************************************
    logic         convTick, sarBusy, sarDone, sarStart, abort;
    adcctl_data_t sarResult;

    adcctl_clk_div u_clk_div (
        .mclk                (mclk),
        .reset_n             (reset_n),
        .srcEn               (clkSrcEn),
        .srcSel              (clkSel_ff),
        .inputClockDivideSel (inputClockDivideSel_ff),
        .convTick            (convTick)
    );

    // A write to SC1, SC2 or CFG aborts; an SC1 write may relaunch in the same cycle
    assign abort = wrSc1 || wrSc2 || wrCfg;

    logic swStart, hwStart, contStart;
    // Channel all ones blocks a software launch; hwStart does not check the channel
    assign swStart   = wrSc1 && !hwTriggerSelect_ff
                     && (hwdata[`ADCCTL_SC1_CH_MSB:`ADCCTL_SC1_CH_LSB] != `ADCCTL_CH_NONE);
    // Edges while busy or after a continuous launch are dropped
    assign hwStart   = hwTriggerSelect_ff && trigRise && hwArmed_ff && !sarBusy;
    assign contStart = seqActive_ff && contEn_ff && !sarBusy && !abort;
    assign sarStart  = swStart || hwStart || contStart;

    adcctl_sar u_sar (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .tick         (convTick),
        .start        (sarStart),
        .abort        (abort),
        .sampleCycles (longSample_ff ? `ADCCTL_SAMPLE_LONG : `ADCCTL_SAMPLE_SHORT),
        .cmpAbove     (cmpAbove),
        .trialCode    (trialCode),
        .busy         (sarBusy),
        .done         (sarDone),
        .result       (sarResult)
    );

    // Continuous sequence and hardware arm tracking
    always_ff @(posedge mclk) begin
        if (!reset_n || abort) begin
            seqActive_ff <= swStart;
            hwArmed_ff   <= 1'b1;
        end else if (hwStart) begin
            seqActive_ff <= 1'b1;
            hwArmed_ff   <= !contEn_ff;
        end else if (sarDone && !contEn_ff) begin
            seqActive_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Result formatting and compare
    // ****************************************************************
    adcctl_data_t fmtResult;
    logic         cmpPass, ge;
    // 8-bit mode keeps the upper eight bits, right-justified
    assign fmtResult = mode8_ff ? {2'b00, sarResult[9:2]} : sarResult;
    assign ge        = (fmtResult >= cmpVal_ff);
    assign cmpPass   = !cmpEn_ff || (cmpGe_ff ? ge : !ge);

    logic resultStore;
    assign resultStore = sarDone && cmpPass;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            result_ff <= `ADCCTL_CMP_RESET;
        end else if (resultStore) begin
            result_ff <= fmtResult;
        end
    end

    // Set wins over clears by result read or SC1 write
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            coco_ff <= 1'b0;
        end else if (resultStore) begin
            coco_ff <= 1'b1;
        end else if (rdResult || wrSc1) begin
            coco_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Control register writes
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            channelSelect_ff <= `ADCCTL_CH_NONE;
            contEn_ff        <= 1'b0;
            irqEn_ff         <= 1'b0;
        end else if (wrSc1) begin
            channelSelect_ff <= hwdata[`ADCCTL_SC1_CH_MSB:`ADCCTL_SC1_CH_LSB];
            contEn_ff        <= hwdata[`ADCCTL_SC1_CONT];
            irqEn_ff         <= hwdata[`ADCCTL_SC1_IE];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hwTriggerSelect_ff <= 1'b0;
            cmpEn_ff           <= 1'b0;
            cmpGe_ff           <= 1'b0;
        end else if (wrSc2) begin
            hwTriggerSelect_ff <= hwdata[`ADCCTL_SC2_TRG];
            cmpEn_ff           <= hwdata[`ADCCTL_SC2_ACFE];
            cmpGe_ff           <= hwdata[`ADCCTL_SC2_ACFGT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            clkSel_ff              <= 2'h0;
            mode8_ff               <= 1'b0;
            longSample_ff          <= 1'b0;
            inputClockDivideSel_ff <= 2'h0;
            lowPower_ff            <= 1'b0;
        end else if (wrCfg) begin
            clkSel_ff              <= hwdata[`ADCCTL_CFG_CLK_MSB:`ADCCTL_CFG_CLK_LSB];
            mode8_ff               <= hwdata[`ADCCTL_CFG_MODE];
            longSample_ff          <= hwdata[`ADCCTL_CFG_LSMP];
            inputClockDivideSel_ff <= hwdata[`ADCCTL_CFG_DIV_MSB:`ADCCTL_CFG_DIV_LSB];
            lowPower_ff            <= hwdata[`ADCCTL_CFG_LPWR];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cmpVal_ff <= `ADCCTL_CMP_RESET;
        end else if (wrCmp) begin
            cmpVal_ff <= hwdata[9:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            analogPinEnable_ff <= '0;
        end else if (wrPin) begin
            analogPinEnable_ff <= hwdata[NUM_PINS-1:0];
        end
    end

    // ****************************************************************
    // Pin control
    // ****************************************************************
    logic [NUM_PINS-1:0] portRead;
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_pin
            assign padOutEnMask[p]  = !analogPinEnable_ff[p];
            assign padInBufEn[p]    = !analogPinEnable_ff[p];
            assign padPullupMask[p] = !analogPinEnable_ff[p];
            assign portRead[p]      = padIn[p] && !analogPinEnable_ff[p];
        end
    endgenerate

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Decoded in the address phase so read data stands through the data phase
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr)
            `ADCCTL_OFF_SC1:    rdMux = {24'h000000, coco_ff, irqEn_ff, contEn_ff,
                                         channelSelect_ff};
            `ADCCTL_OFF_SC2:    rdMux = {24'h000000, sarBusy, hwTriggerSelect_ff,
                                         cmpEn_ff, cmpGe_ff, 4'h0};
            `ADCCTL_OFF_CFG:    rdMux = {24'h000000, lowPower_ff, inputClockDivideSel_ff,
                                         longSample_ff, 1'b0, mode8_ff, clkSel_ff};
            `ADCCTL_OFF_RESULT: rdMux = {22'h000000, result_ff};
            `ADCCTL_OFF_CMPVAL: rdMux = {22'h000000, cmpVal_ff};
            `ADCCTL_OFF_PINEN:  rdMux = 32'(analogPinEnable_ff);
            `ADCCTL_OFF_PORTIN: rdMux = 32'(portRead);
            default:            rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    assign channelSelect = channelSelect_ff;
    assign lowPower      = lowPower_ff;
    assign sampling      = sarBusy;
    assign convIrq       = coco_ff && irqEn_ff;
endmodule

/* File: tb/adcctl_chk.sv */
// Port checker for the converter control block, bound to its top module
`timescale 1ns/1ps
`include "adcctl_defs.svh"
module adcctl_chk #(
    parameter int NUM_PINS = 28
) (
    // Clock, reset and bus
    input wire logic                mclk,
    input wire logic                reset_n,
    input wire logic                hsel,
    input wire logic [11:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    // Converter and pins
    input wire logic                hwConversionTriggerIn,
    input wire logic [4:0]          channelSelect,
    input wire logic                lowPower,
    input wire logic                sampling,
    input wire logic                convIrq,
    input wire logic [NUM_PINS-1:0] padOutEnMask,
    input wire logic [NUM_PINS-1:0] padInBufEn,
    input wire logic [NUM_PINS-1:0] padPullupMask
);
    logic [11:0] wrAddr_ff;
    logic        wrPh_ff;
    logic        trgSel_ff;
    logic        contSel_ff;
    logic [7:0]  runCnt_ff;
    logic        wrSc1;
    assign wrSc1 = wrPh_ff && wrAddr_ff == `ADCCTL_OFF_SC1;
    // ****************************************************************
    // Shadow of the bus writes the properties depend on
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (hready) wrAddr_ff <= haddr;
        if (!reset_n) wrPh_ff <= 1'h0;
        else if (hready) wrPh_ff <= hsel & htrans[1] & hwrite;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trgSel_ff <= 1'h0;
            contSel_ff <= 1'h0;
        end else if (wrPh_ff) begin
            if (wrAddr_ff == `ADCCTL_OFF_SC2) trgSel_ff <= hwdata[6];
            if (wrAddr_ff == `ADCCTL_OFF_SC1) contSel_ff <= hwdata[5];
        end
    end
    // Saturates so a stuck converter cannot wrap into a short run
    always_ff @(posedge mclk) begin
        if (!reset_n || !sampling) runCnt_ff <= 8'h00;
        else if (runCnt_ff != 8'hFF) runCnt_ff <= runCnt_ff + 8'h01;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_pinIn; padInBufEn == padOutEnMask; endproperty
    a_pinIn: assert property (p_pinIn) else $error("input buffer mask differs");
    property p_pinPull; padPullupMask == padOutEnMask; endproperty
    a_pinPull: assert property (p_pinPull) else $error("pullup mask differs");
    property p_chan; wrSc1 |=> channelSelect == $past(hwdata[4:0]); endproperty
    a_chan: assert property (p_chan) else $error("channel not written");
    property p_lowPwr;
        wrPh_ff && wrAddr_ff == `ADCCTL_OFF_CFG |=> lowPower == $past(hwdata[7]);
    endproperty
    a_lowPwr: assert property (p_lowPwr) else $error("low power not written");
    property p_swStart;
        wrSc1 && hwdata[4:0] != 5'h1F && !trgSel_ff |-> ##[1:2] sampling;
    endproperty
    a_swStart: assert property (p_swStart) else $error("software start missing");
    property p_offNoStart; wrSc1 && hwdata[4:0] == 5'h1F |=> !sampling [*4]; endproperty
    a_offNoStart: assert property (p_offNoStart) else $error("start with channel off");
    property p_trgStart;
        $rose(hwConversionTriggerIn) && trgSel_ff && !contSel_ff && !sampling && !wrPh_ff
            |-> ##[1:8] sampling;
    endproperty
    a_trgStart: assert property (p_trgStart) else $error("trigger start missing");
    property p_convLen;
        $fell(sampling) |-> runCnt_ff >= 8'h0C || $past(wrPh_ff) || $past(wrPh_ff, 2);
    endproperty
    a_convLen: assert property (p_convLen) else $error("conversion too short");
    property p_irqRise;
        $rose(convIrq) |-> $past(sampling) || $past(sampling, 2) || $past(sampling, 3);
    endproperty
    a_irqRise: assert property (p_irqRise) else $error("flag without conversion");
endmodule
bind adcctl_top adcctl_chk #(.NUM_PINS(NUM_PINS)) u_chk (
    .mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hwConversionTriggerIn, .channelSelect, .lowPower, .sampling, .convIrq,
    .padOutEnMask, .padInBufEn, .padPullupMask
);

/* File: tb/adcctl_analog_model.sv */
// Analog inputs, port pads and hardware trigger source seen by the converter
`timescale 1ns/1ps
module adcctl_analog_model (
    // Clock
    input  wire logic               mclk,
    // Converter side
    input  adcctl_pkg::adcctl_data_t trialCode,
    input  wire logic [4:0]         channelSelect,
    output logic                    cmpAbove,
    output logic                    hwConversionTriggerIn,
    output logic [27:0]             padIn
);
    import adcctl_pkg::*;
    // Each channel holds a distinct level so a wrong channel shows in the result
    assign cmpAbove = {channelSelect, 5'h15} >= trialCode;
    assign padIn = 28'hFFFFFFF;
    initial hwConversionTriggerIn = 1'h0;
    // Held two cycles so the synchroniser always sees it once
    task automatic fireTrigger;
        @(posedge mclk);
        hwConversionTriggerIn <= 1'h1;
        repeat (2) @(posedge mclk);
        hwConversionTriggerIn <= 1'h0;
    endtask
endmodule

/* File: tb/adcctl_tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcctl_defs.svh"
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin badCount++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module adcctl_tb_top;
    import adcctl_pkg::*;
    logic         mclk = 1'h0;
    logic         reset_n = 1'h0;
    logic         hsel = 1'h0;
    logic [11:0]  haddr = 12'h000;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'h0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  hwdata = 32'h0;
    logic [3:0]   clkSrcEn = 4'hF;
    logic [31:0]  hrdata;
    logic         hreadyout, hresp, cmpAbove, trig, sampling, lowPower, convIrq;
    adcctl_data_t trialCode;
    logic [4:0]   channelSelect;
    logic [27:0]  padIn, padOutEnMask, padInBufEn, padPullupMask;
    int           badCount = 0;
    int           samplesChecked = 0;
    int           cyc = 0;
    adcctl_top #(.NUM_PINS(28)) DUT (
        .mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .clkSrcEn,
        .hwConversionTriggerIn(trig), .cmpAbove, .trialCode, .channelSelect,
        .lowPower, .sampling, .padIn, .padOutEnMask, .padInBufEn, .padPullupMask, .convIrq
    );
    adcctl_analog_model m (
        .mclk, .trialCode, .channelSelect, .cmpAbove, .hwConversionTriggerIn(trig), .padIn
    );
    initial forever #2 mclk = ~mclk;
    // ****************************************************************
    // Bus and run tasks
    // ****************************************************************
    // Read data is taken at the edge that ends the data phase
    task automatic busXfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                           output logic [31:0] q);
        @(posedge mclk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'h1);
        q = hrdata;
        hsel <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        busXfer(a, 1'h1, d, q);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] ex);
        logic [31:0] q;
        busXfer(a, 1'h0, 32'h0, q);
        `CHK("read", ex, q)
    endtask
    task automatic runConv(output int n);
        int t;
        n = 0;
        t = 0;
        while (sampling !== 1'h1 && t < 40) begin
            @(posedge mclk);
            t++;
        end
        while (sampling === 1'h1 && n < 600) begin
            @(posedge mclk);
            n++;
        end
        repeat (3) @(posedge mclk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            badCount++;
            summarize();
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        int n;
        repeat (8) @(posedge mclk);
        reset_n <= 1'h1;
        rdChk(`ADCCTL_OFF_SC1, 32'h1F);
        wr(`ADCCTL_OFF_PINEN, 32'h5);
        `CHK("oe", 28'hFFFFFFA, padOutEnMask)
        `CHK("ib", 28'hFFFFFFA, padInBufEn)
        `CHK("pu", 28'hFFFFFFA, padPullupMask)
        rdChk(`ADCCTL_OFF_PORTIN, 32'h0FFFFFFA);
        rdChk(12'h01C, 32'h0);
        for (int d = 0; d < 4; d++) begin
            wr(`ADCCTL_OFF_CFG, 32'(d) << 5);
            wr(`ADCCTL_OFF_SC1, 32'h55);
            runConv(n);
            `CHK("div", 1'h1, n >= (14 << d) - 3 && n <= (16 << d) + 3)
            `CHK("irq", 1'h1, convIrq)
            rdChk(`ADCCTL_OFF_RESULT, 32'h2B5);
            `CHK("irqclr", 1'h0, convIrq)
        end
        wr(`ADCCTL_OFF_CFG, 32'h84);
        wr(`ADCCTL_OFF_SC1, 32'h55);
        runConv(n);
        rdChk(`ADCCTL_OFF_RESULT, 32'hAD);
        wr(`ADCCTL_OFF_CFG, 32'h0);
        wr(`ADCCTL_OFF_SC1, 32'h5F);
        repeat (6) @(posedge mclk);
        `CHK("off", 1'h0, sampling)
        wr(`ADCCTL_OFF_CMPVAL, 32'h300);
        wr(`ADCCTL_OFF_SC2, 32'h30);
        wr(`ADCCTL_OFF_SC1, 32'h55);
        runConv(n);
        `CHK("ge", 1'h0, convIrq)
        wr(`ADCCTL_OFF_SC2, 32'h20);
        wr(`ADCCTL_OFF_SC1, 32'h55);
        runConv(n);
        `CHK("lt", 1'h1, convIrq)
        wr(`ADCCTL_OFF_SC2, 32'h60);
        wr(`ADCCTL_OFF_SC1, 32'h55);
        repeat (6) @(posedge mclk);
        `CHK("hwsw", 1'h0, sampling)
        m.fireTrigger();
        runConv(n);
        `CHK("hw", 1'h1, n >= 11)
        `CHK("hwcmp", 1'h1, convIrq)
        m.fireTrigger();
        m.fireTrigger();
        runConv(n);
        repeat (10) @(posedge mclk);
        `CHK("drop", 1'h0, sampling)
        wr(`ADCCTL_OFF_SC2, 32'h0);
        m.fireTrigger();
        repeat (8) @(posedge mclk);
        `CHK("swmode", 1'h0, sampling)
        wr(`ADCCTL_OFF_SC2, 32'h40);
        wr(`ADCCTL_OFF_SC1, 32'h75);
        m.fireTrigger();
        runConv(n);
        runConv(n);
        `CHK("cont", 1'h1, n >= 11)
        rdChk(`ADCCTL_OFF_RESULT, 32'h2B5);
        wr(`ADCCTL_OFF_SC2, 32'h0);
        repeat (4) @(posedge mclk);
        `CHK("abort", 1'h0, sampling)
        summarize();
    end
endmodule
